// ### src/spa_cfg.svh
`ifndef SPA_CFG_SVH
`define SPA_CFG_SVH
`define SPA_OFF_ADDR_HIGH   12'h1f0
`define SPA_OFF_ADDR_LOW    12'h1f4
`define SPA_OFF_CMD         12'h1f8
`define SPA_OFF_DATA        12'h1fc
`define SPA_OFF_WIN_FIRST   12'h200
`define SPA_OFF_WIN_LAST    12'h2dc
`define SPA_RST_ADDR_HIGH   32'h0024ffff
`define SPA_RST_ADDR_LOW    32'hff0f8000
`define SPA_RST_WIN_DATA    32'h00000000
`define SPA_HIGH_MASK       32'h007fffff
`define SPA_CMD_MASK        32'hc00fffff
`define SPA_BIT_PER_PORT    22
`define SPA_BIT_BUSY        31
`define SPA_BIT_DIR         30
`define SPA_BE_ALL          4'hf
`define SPA_DIR_WRITE       1'b0
`define SPA_DIR_READ        1'b1
`define SPA_EE_FIRST        3'h1
`define SPA_EE_LAST         3'h6
`define SPA_EE_HIGH_FIRST   3'h5
`define SPA_RESP_OKAY       2'h0
`define SPA_RESP_SLVERR     2'h2
`define SPA_RESP_DECERR     2'h3
`define SPA_WIN_COUNT       48
`define SPA_IDX_W           6
`define SPA_CSR_UNKNOWN     16'h0000
`endif

// ### src/spa_csr_map.sv
`include "spa_cfg.svh"
// window word index to fabric register number
module spa_csr_map (
  input  wire logic [5:0]  idx,
  output logic      [15:0] csr_num
);
  always_comb begin
    case (idx)
      6'h00: csr_num = 16'h0001;
      6'h01: csr_num = 16'h0004;
      6'h02: csr_num = 16'h0401;
      6'h03: csr_num = 16'h0440;
      6'h04: csr_num = 16'h0441;
      6'h05: csr_num = 16'h0480;
      6'h06: csr_num = 16'h0801;
      6'h07: csr_num = 16'h0840;
      6'h08: csr_num = 16'h0841;
      6'h09: csr_num = 16'h0880;
      6'h0a: csr_num = 16'h0c01;
      6'h0b: csr_num = 16'h0c40;
      6'h0c: csr_num = 16'h0c41;
      6'h0d: csr_num = 16'h0c80;
      6'h0e: csr_num = 16'h1800;
      6'h0f: csr_num = 16'h1801;
      6'h10: csr_num = 16'h1802;
      6'h11: csr_num = 16'h1809;
      6'h12: csr_num = 16'h180b;
      6'h13: csr_num = 16'h180c;
      6'h14: csr_num = 16'h1811;
      6'h15: csr_num = 16'h1812;
      6'h16: csr_num = 16'h1840;
      6'h17: csr_num = 16'h1841;
      6'h18: csr_num = 16'h1842;
      6'h19: csr_num = 16'h1843;
      6'h1a: csr_num = 16'h1845;
      6'h1b: csr_num = 16'h1846;
      6'h1c: csr_num = 16'h1847;
      6'h1d: csr_num = 16'h1848;
      6'h1e: csr_num = 16'h1849;
      6'h1f: csr_num = 16'h184a;
      6'h20: csr_num = 16'h184b;
      6'h21: csr_num = 16'h184d;
      6'h22: csr_num = 16'h1855;
      6'h23: csr_num = 16'h1856;
      6'h24: csr_num = 16'h1857;
      6'h25: csr_num = 16'h1880;
      6'h26: csr_num = 16'h1c00;
      6'h27: csr_num = 16'h1c01;
      6'h28: csr_num = 16'h1c02;
      6'h29: csr_num = 16'h1c03;
      6'h2a: csr_num = 16'h1c04;
      6'h2b: csr_num = 16'h1c09;
      6'h2c: csr_num = 16'h1c0a;
      6'h2d: csr_num = 16'h1c0c;
      6'h2e: csr_num = 16'h1c0d;
      6'h2f: csr_num = 16'h1c0e;
      6'h30: csr_num = 16'h1c0f;
      6'h31: csr_num = 16'h1c10;
      6'h32: csr_num = 16'h1c11;
      6'h33: csr_num = 16'h1c12;
      6'h34: csr_num = 16'h1c13;
      6'h35: csr_num = 16'h1c14;
      6'h36: csr_num = 16'h1c15;
      6'h37: csr_num = 16'h1c20;
      default: csr_num = `SPA_CSR_UNKNOWN;
    endcase
  end
endmodule // spa_csr_map

// ### src/spa_pkg.sv
package spa_pkg;
  typedef enum logic [1:0] {
    SPA_IDLE = 2'b00,
    SPA_ISSUE = 2'b01,
    SPA_WAIT = 2'b11
  } spa_fab_state_t;
endpackage

// ### src/spa_regs.sv
`include "spa_cfg.svh"
module spa_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ee_programmed,
  input  wire logic        ee_byte_valid,
  input  wire logic [2:0]  ee_byte_addr,
  input  wire logic [7:0]  ee_byte_data,
  input  wire logic        ee_load_done,
  output logic             fab_req,
  output logic [15:0]      fabric_reg_select,
  output logic [3:0]       fabric_byte_lanes,
  output logic             fabric_direction,
  output logic [31:0]      fab_wdata,
  input  wire logic        fab_done,
  input  wire logic [31:0] fab_rdata,
  output logic [47:0]      port0_pause_sa,
  output logic [47:0]      port1_pause_sa,
  output logic [47:0]      port2_pause_sa
);
  typedef struct packed {
    logic                    awr;
    logic                    wr;
    logic [11:0]             aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    awrdy;
    logic                    wrdy;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    init_done;
    logic [31:0]             addr_high;
    logic [31:0]             addr_low;
    logic [31:0]             cmd;
    logic [31:0]             data;
    logic                    pend;
    logic                    req;
    spa_pkg::spa_fab_state_t fst;
    logic [47:0]             sa0;
    logic [47:0]             sa1;
    logic [47:0]             sa2;
  } spa_state_t;

  spa_state_t st_ff;
  spa_state_t nxt_st;
  logic [15:0] win_csr;
  logic [`SPA_IDX_W-1:0] win_idx;
  logic [2:0]            wr_sel;
  logic [2:0]            rd_sel;

  // register select codes returned by the address decoder
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_LOW  = 3'h2;
  localparam logic [2:0] SEL_CMD  = 3'h3;
  localparam logic [2:0] SEL_DATA = 3'h4;
  localparam logic [2:0] SEL_WIN  = 3'h5;

  // byte-lane merge, used for host writes to the high, low and data registers
  function automatic logic [31:0] spa_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [47:0] spa_port_sa(input logic [31:0] hi, input logic [31:0] lo,
                                              input logic [1:0] pbits);
    logic [47:0] a;
    a = {hi[15:0], lo};
    if (hi[`SPA_BIT_PER_PORT]) begin
      a[41:40] = pbits;
    end
    return a;
  endfunction

  // shared by the write and read paths so both sides see the same map
  function automatic logic [2:0] spa_decode(input logic [11:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a == `SPA_OFF_ADDR_HIGH) begin
      s = SEL_HIGH;
    end else if (a == `SPA_OFF_ADDR_LOW) begin
      s = SEL_LOW;
    end else if (a == `SPA_OFF_CMD) begin
      s = SEL_CMD;
    end else if (a == `SPA_OFF_DATA) begin
      s = SEL_DATA;
    end else if (a >= `SPA_OFF_WIN_FIRST && a <= `SPA_OFF_WIN_LAST) begin
      s = SEL_WIN;
    end
    return s;
  endfunction

  // word index inside the window; only meaningful when the address decodes as window
  assign win_idx = 6'((st_ff.aw_addr - `SPA_OFF_WIN_FIRST) >> 2);
  assign wr_sel = spa_decode(st_ff.aw_addr);
  assign rd_sel = spa_decode(s_axi_araddr);

  spa_csr_map u_map (
    .idx     (win_idx),
    .csr_num (win_csr)
  );

  always_comb begin
    nxt_st = st_ff;
    if (s_axi_awvalid && st_ff.awrdy) begin
      nxt_st.awr = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wrdy) begin
      nxt_st.wr = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // loader bytes, on-wire order: 01h..04h low, 05h..06h high
    if (!st_ff.init_done && ee_programmed && ee_byte_valid) begin
      if (ee_byte_addr >= `SPA_EE_FIRST && ee_byte_addr < `SPA_EE_HIGH_FIRST) begin
        nxt_st.addr_low[(ee_byte_addr - `SPA_EE_FIRST)*8 +: 8] = ee_byte_data;
      end else if (ee_byte_addr >= `SPA_EE_HIGH_FIRST && ee_byte_addr <= `SPA_EE_LAST) begin
        nxt_st.addr_high[(ee_byte_addr - `SPA_EE_HIGH_FIRST)*8 +: 8] = ee_byte_data;
      end
    end
    if (ee_load_done) begin
      nxt_st.init_done = 1'b1;
    end
    // write completes when address and data both held
    if (st_ff.awr && st_ff.wr) begin
      nxt_st.awr = 1'b0;
      nxt_st.wr = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `SPA_RESP_OKAY;
      if (!st_ff.init_done) begin
        nxt_st.bresp = `SPA_RESP_SLVERR;
      end else if (wr_sel == SEL_HIGH) begin
        nxt_st.addr_high = spa_merge(st_ff.addr_high, st_ff.w_data, st_ff.w_strb)
                           & `SPA_HIGH_MASK;
      end else if (wr_sel == SEL_LOW) begin
        nxt_st.addr_low = spa_merge(st_ff.addr_low, st_ff.w_data, st_ff.w_strb);
      end else if (wr_sel == SEL_CMD) begin
        if (st_ff.pend) begin
          nxt_st.bresp = `SPA_RESP_SLVERR;
        end else begin
          nxt_st.cmd = st_ff.w_data & `SPA_CMD_MASK;
          nxt_st.pend = st_ff.w_data[`SPA_BIT_BUSY];
        end
      end else if (wr_sel == SEL_DATA) begin
        // the data word drives the fabric while busy, so it is locked until done
        if (st_ff.pend) begin
          nxt_st.bresp = `SPA_RESP_SLVERR;
        end else begin
          nxt_st.data = spa_merge(st_ff.data, st_ff.w_data, st_ff.w_strb);
        end
      end else if (wr_sel == SEL_WIN) begin
        if (st_ff.pend) begin
          nxt_st.bresp = `SPA_RESP_SLVERR;
        end else begin
          nxt_st.cmd = '0;
          nxt_st.cmd[15:0] = win_csr;
          nxt_st.cmd[19:16] = `SPA_BE_ALL;
          nxt_st.cmd[`SPA_BIT_DIR] = `SPA_DIR_WRITE;
          nxt_st.cmd[`SPA_BIT_BUSY] = 1'b1;
          nxt_st.data = st_ff.w_data;
          nxt_st.pend = 1'b1;
        end
      end else begin
        nxt_st.bresp = `SPA_RESP_DECERR;
      end
    end
    // fabric handshake
    case (st_ff.fst)
      spa_pkg::SPA_IDLE: begin
        if (st_ff.pend) begin
          nxt_st.fst = spa_pkg::SPA_ISSUE;
        end
      end
      spa_pkg::SPA_ISSUE: begin
        nxt_st.fst = spa_pkg::SPA_WAIT;
      end
      spa_pkg::SPA_WAIT: begin
        if (fab_done) begin
          nxt_st.fst = spa_pkg::SPA_IDLE;
          nxt_st.pend = 1'b0;
          nxt_st.cmd[`SPA_BIT_BUSY] = 1'b0;
          if (st_ff.cmd[`SPA_BIT_DIR] == `SPA_DIR_READ) begin
            nxt_st.data = fab_rdata;
          end
        end
      end
      default: nxt_st.fst = spa_pkg::SPA_IDLE;
    endcase
    // reads; window is write-only and answers zero
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // read data is raised only after the address handshake edge
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `SPA_RESP_OKAY;
      nxt_st.rdata = '0;
      if (rd_sel == SEL_HIGH) begin
        nxt_st.rdata = st_ff.addr_high;
      end else if (rd_sel == SEL_LOW) begin
        nxt_st.rdata = st_ff.addr_low;
      end else if (rd_sel == SEL_CMD) begin
        nxt_st.rdata = st_ff.cmd;
      end else if (rd_sel == SEL_DATA) begin
        nxt_st.rdata = st_ff.data;
      end else if (rd_sel == SEL_WIN) begin
        nxt_st.rdata = '0;
      end else begin
        nxt_st.rresp = `SPA_RESP_DECERR;
      end
    end
    // ready flags are registered so every bus output leaves a flop;
    // a channel reopens in the same cycle its slot empties, costing no throughput here
    nxt_st.awrdy = !nxt_st.awr && !nxt_st.bvalid;
    nxt_st.wrdy = !nxt_st.wr && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;
    nxt_st.req = (nxt_st.fst == spa_pkg::SPA_ISSUE);
    // byte 0 of the 48-bit value is the first on-wire byte; nibble order kept as stored
    nxt_st.sa0 = spa_port_sa(st_ff.addr_high, st_ff.addr_low, st_ff.addr_high[17:16]);
    nxt_st.sa1 = spa_port_sa(st_ff.addr_high, st_ff.addr_low, st_ff.addr_high[19:18]);
    nxt_st.sa2 = spa_port_sa(st_ff.addr_high, st_ff.addr_low, st_ff.addr_high[21:20]);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.addr_high <= `SPA_RST_ADDR_HIGH;
      st_ff.addr_low <= `SPA_RST_ADDR_LOW;
      st_ff.data <= `SPA_RST_WIN_DATA;
      st_ff.fst <= spa_pkg::SPA_IDLE;
      st_ff.awrdy <= 1'b1;
      st_ff.wrdy <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awrdy;
  assign s_axi_wready = st_ff.wrdy;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign fab_req = st_ff.req;
  assign fabric_reg_select = st_ff.cmd[15:0];
  assign fabric_byte_lanes = st_ff.cmd[19:16];
  assign fabric_direction = st_ff.cmd[`SPA_BIT_DIR];
  assign fab_wdata = st_ff.data;
  assign port0_pause_sa = st_ff.sa0;
  assign port1_pause_sa = st_ff.sa1;
  assign port2_pause_sa = st_ff.sa2;
endmodule // spa_regs

// ### verification/spa_fab_model.sv
module spa_fab_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        fab_req,
  input  wire logic [15:0] fabric_reg_select,
  input  wire logic [3:0]  fabric_byte_lanes,
  input  wire logic [31:0] fab_wdata,
  input  wire logic [7:0]  delay,
  output logic             fab_done,
  output logic [31:0]      fab_rdata,
  output logic [15:0]      seen_sel,
  output logic [31:0]      seen_img
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always @(posedge sys_clk) begin
    fab_done <= 1'h0;
    // read data toggles so a stale value is never mistaken for an answer
    fab_rdata <= ~fab_rdata;
    if (!rst_n) begin
      cnt <= 0;
      fab_rdata <= 32'h0f0f0f0f;
    end else if (fab_req) begin
      seen_sel <= fabric_reg_select;
      for (int i = 0; i < 4; i++)
        if (fabric_byte_lanes[i]) seen_img[8*i +: 8] <= fab_wdata[8*i +: 8];
      cnt <= delay + 1;
    end else if (cnt == 1) begin
      fab_done <= 1'h1;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule // spa_fab_model

// ### verification/spa_regs_props.sv
module spa_regs_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        fab_req,
  input wire logic [15:0] fabric_reg_select,
  input wire logic [3:0]  fabric_byte_lanes,
  input wire logic        fabric_direction,
  input wire logic [31:0] fab_wdata,
  input wire logic        fab_done,
  input wire logic [47:0] port0_pause_sa,
  input wire logic [47:0] port1_pause_sa,
  input wire logic [47:0] port2_pause_sa
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] aw_ff;
  logic        pend_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_ff <= 12'h000;
      pend_ff <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
      if (fab_req) pend_ff <= 1'h1;
      else if (fab_done) pend_ff <= 1'h0;
    end
  end
  sequence win_ok;
    $rose(s_axi_bvalid) && s_axi_bresp == 2'h0 && aw_ff >= 12'h200 && aw_ff <= 12'h2dc;
  endsequence
  sequence launch;
    ##[1:3] (fab_req && fabric_byte_lanes == 4'hf && fabric_direction == 1'h0);
  endsequence
  win_launch_a: assert property (win_ok |-> launch)
    else $error("window write did not launch a full write");
  win_map_a: assert property (win_ok and aw_ff == 12'h208 |-> ##[1:3]
    (fab_req && fabric_reg_select == 16'h0401)) else $error("window map wrong");
  req_pulse_a: assert property (fab_req |=> !fab_req)
    else $error("fabric request longer than one cycle");
  one_pending_a: assert property (pend_ff |-> !fab_req)
    else $error("new fabric request while one pending");
  req_hold_a: assert property (pend_ff |-> $stable(fabric_reg_select) &&
    $stable(fab_wdata) && $stable(fabric_byte_lanes)) else $error("request moved");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  sa_common_a: assert property (port0_pause_sa[47:42] == port2_pause_sa[47:42] &&
    port0_pause_sa[39:0] == port1_pause_sa[39:0]) else $error("ports differ off 41:40");
  sa_reset_a: assert property ($rose(rst_n) |=>
    port1_pause_sa == 48'hffffff0f8000) else $error("pause address reset wrong");
endmodule // spa_regs_chk

bind spa_regs spa_regs_chk u_chk (.*);

// ### verification/tb_switch_pause_addr_and_direct_csr_write.sv
module tb_switch_pause_addr_and_direct_csr_write;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'h0, rst_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, fab_wdata, fab_rdata, seen_img, d, h, rd_seen;
  logic [3:0]  s_axi_wstrb = 4'hf, fabric_byte_lanes;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        fab_req, fabric_direction, fab_done;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        ee_programmed = 1'h0, ee_byte_valid = 1'h0, ee_load_done = 1'h0;
  logic [2:0]  ee_byte_addr = 3'h0;
  logic [7:0]  ee_byte_data = 8'h0, delay = 8'h1;
  logic [15:0] fabric_reg_select, seen_sel;
  logic [47:0] port0_pause_sa, port1_pause_sa, port2_pause_sa, v;
  logic [47:0] sa [3];
  int          errors = 0, samples_checked = 0;
  localparam logic [15:0] MAPT [10] = '{16'h0001, 16'h0004, 16'h0401, 16'h0440, 16'h0441,
                                        16'h0480, 16'h0801, 16'h0840, 16'h0841, 16'h0880};
  assign sa[0] = port0_pause_sa;
  assign sa[1] = port1_pause_sa;
  assign sa[2] = port2_pause_sa;
  spa_regs DUT (.*);
  spa_fab_model u_fab (.*);
  always #4 sys_clk = ~sys_clk;
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
    int n;
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    hb = 1'h0;
    n = 0;
    while (!hb && n < 50) begin
      @(negedge sys_clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    if (!hb) begin
      errors++;
      results;
    end
    chk(r, er);
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int n;
    logic ha, hr;
    logic [31:0] dr;
    logic [1:0] r;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    hr = 1'h0;
    n = 0;
    while (!hr && n < 50) begin
      @(negedge sys_clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      dr = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ha) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    if (!hr) begin
      errors++;
      results;
    end
    chk(dr & m, e);
    chk(r, er);
  endtask
  task automatic ee_load(input logic [47:0] lv, input logic p);
    ee_programmed <= p;
    for (int i = 1; i <= 6; i++) begin
      @(posedge sys_clk);
      ee_byte_valid <= 1'h1;
      ee_byte_addr <= i[2:0];
      ee_byte_data <= lv[8*(i-1) +: 8];
    end
    @(posedge sys_clk);
    ee_byte_valid <= 1'h0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      rd_seen = fab_rdata;
      n++;
    end while (fab_done !== 1'h1 && n < 100);
    if (fab_done !== 1'h1) begin
      errors++;
      results;
    end
  endtask
  // common bits 41:40 give way to the port's own field when enabled
  function automatic logic [47:0] exp_sa(input logic [31:0] hi, lo, input int p);
    logic [47:0] s;
    s = {hi[15:0], lo};
    if (hi[22]) s[41:40] = hi[16+2*p +: 2];
    return s;
  endfunction
  initial begin
    void'($urandom(71614));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    axw(12'h1f4, 32'h12345678, 2'h2);
    axr(12'h1f0, 32'h0024ffff, 32'h007fffff, 2'h0);
    axr(12'h1f4, 32'hff0f8000, 32'hffffffff, 2'h0);
    $display("test 1 done");
    v = {$urandom, $urandom};
    ee_load(~v, 1'h0);
    axr(12'h1f4, 32'hff0f8000, 32'hffffffff, 2'h0);
    ee_load(v, 1'h1);
    ee_load_done <= 1'h1;
    axr(12'h1f4, v[31:0], 32'hffffffff, 2'h0);
    axr(12'h1f0, {16'h0000, v[47:32]}, 32'h0000ffff, 2'h0);
    chk(port0_pause_sa, exp_sa({16'h0024, v[47:32]}, v[31:0], 0));
    $display("test 2 done");
    for (int k = 0; k < 4; k++) begin
      h = $urandom & 32'h007fffff;
      h[22] = k[0];
      axw(12'h1f0, h, 2'h0);
      axr(12'h1f0, h, 32'h007fffff, 2'h0);
      for (int p = 0; p < 3; p++) chk(sa[p], exp_sa(h, v[31:0], p));
    end
    $display("test 3 done");
    for (int i = 0; i < 10; i++) begin
      d = $urandom;
      delay <= (i == 0) ? 8'h14 : 8'h01 + 8'($urandom % 8);
      axw(12'h200 + 12'(4 * i), d, 2'h0);
      if (i == 0) axw(12'h204, ~d, 2'h2);
      wait_done;
      chk(seen_sel, MAPT[i]);
      chk(seen_img, d);
      axr(12'h1f8, {12'h000, 4'hf, MAPT[i]}, 32'hc00fffff, 2'h0);
    end
    axr(12'h2dc, 32'h0, 32'hffffffff, 2'h0);
    axw(12'h1f8, 32'hc00f1c20, 2'h0);
    wait_done;
    chk(seen_sel, 16'h1c20);
    axr(12'h1fc, rd_seen, 32'hffffffff, 2'h0);
    axr(12'h1f8, 32'h400f1c20, 32'hc00fffff, 2'h0);
    $display("test 4 done");
    axw(12'h2e0, 32'h0, 2'h3);
    axw(12'h100, 32'h0, 2'h3);
    axr(12'h100, 32'h0, 32'hffffffff, 2'h3);
    $display("test 5 done");
    results;
  end
endmodule // tb_switch_pause_addr_and_direct_csr_write
